// [rtl/seq_pkg.sv]
// Shared constants for the step pattern shift sequencer.
package seq_pkg;

    localparam int STAGES   = 16;
    localparam int HALF     = 8;
    localparam int BUSES    = 3;
    localparam int ROUTE_W  = 2;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] CTRL_OFFS    = 8'h00;
    localparam logic [ADDR_W-1:0] PATTERN_OFFS = 8'h04;
    localparam logic [ADDR_W-1:0] ROUTE_OFFS   = 8'h08;
    localparam logic [ADDR_W-1:0] CMD_OFFS     = 8'h0C;
    localparam logic [ADDR_W-1:0] STATUS_OFFS  = 8'h10;

    // Control register fields.
    localparam int CTRL_CLK_EN_BIT      = 0;
    localparam int CTRL_RANDOM_BIT      = 1;
    localparam int CTRL_LOOP16_BIT      = 2;
    localparam int CTRL_INVERT_B_BIT    = 3;
    localparam int CTRL_EXT_LOAD_EN_BIT = 4;
    localparam int CTRL_BUS1_RELOAD_BIT = 5;
    localparam int CTRL_MERGE_LSB       = 8;
    localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0000_073F;

    // Command register fields, write only.
    localparam int CMD_LOAD_BIT = 0;
    localparam int CMD_STEP_BIT = 1;

    // Status register fields; the stage bits sit at the bottom.
    localparam int STAT_GATE_LSB   = 16;
    localparam int STAT_RAND_BIT   = 19;
    localparam int STAT_MASTER_BIT = 20;

    // Reset values.
    localparam logic [DATA_W-1:0] CTRL_RESET    = 32'h0000_0011;
    localparam logic [STAGES-1:0] PATTERN_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] ROUTE_RESET   = 32'h0000_0000;

    // Trigger pulse length.
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TRIG_TIME_NS  = 1000;
    localparam int TRIG_CYCLES   = (TRIG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// [rtl/gate_bus_shaper.sv]
// One gate bus output stage: gate level and trigger pulse.
`timescale 1ns/1ps
module gate_bus_shaper #(
    parameter int TRIG_CYCLES = seq_pkg::TRIG_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic ce,
    input  wire logic active,
    input  wire logic clk_level,
    input  wire logic fire,
    input  wire logic merge,
    output logic      gate_q,
    output logic      trig_q
);
    localparam int CW = $clog2(TRIG_CYCLES + 1);

    logic [CW-1:0] cnt_q;
    logic          held_q;
    wire           start;
    wire  [CW-1:0] cnt_d;

    // A merged bus fires only when it was idle at the previous step.
    assign start = fire & active & (~merge | ~held_q);
    assign cnt_d = start ? CW'(TRIG_CYCLES)
                 : (cnt_q != '0) ? cnt_q - 1'b1 : '0;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gate_q <= 1'b0;
            trig_q <= 1'b0;
            held_q <= 1'b0;
            cnt_q  <= '0;
        end
        else if (ce)
        begin
            gate_q <= merge ? active : (active & clk_level);
            trig_q <= (cnt_d != '0);
            cnt_q  <= cnt_d;
            if (fire)
            begin
                held_q <= active;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_merge_gate_held: assert property (
        merge && active && ce |=> gate_q)
        else $error("Merged bus gate dropped while the bus was active.");

    a_merge_no_retrig: assert property (
        fire && merge && held_q && active && cnt_q == '0 && ce |=> !trig_q)
        else $error("Merged bus retriggered on a consecutive active step.");

    a_split_gate_clock: assert property (
        !merge && !clk_level && ce |=> !gate_q)
        else $error("Unmerged gate stayed high while the clock was low.");

    a_trig_start: assert property (
        start && ce |=> trig_q)
        else $error("Trigger did not start after an active step.");

endmodule

// [rtl/step_sequencer_core.sv]
// Digital core of a sixteen stage step pattern shift sequencer.
// Notes on behaviour
// - Sixteen programmed pattern bits form the pattern copied into the register.
// - Each step routes its active bit to exactly one of three gate buses.
// - Each bus has a merge control joining consecutive active steps into one gate.
// - With reload enabled, a rising gate on bus one reloads the pattern.
// - Mode selects recirculating the pattern or taking new bits from random.
// - Length selects two independent eight stage loops or one sixteen stage loop.
// - Invert option inverts data recirculated in section B before re-entry.
// - In random mode a one is inserted when random input is above threshold.
// - External load input is gated by its enable; disabled pulses do nothing.
// - A manual load copies the programmed pattern into the register.
// - Each manual step advances the register one position, clock independent.
// - A rising edge on the enabled external load input starts a load.
// - Stages one to eight are section A, nine to sixteen section B.
`timescale 1ns/1ps
module step_sequencer_core #(
    parameter int TRIG_CYCLES = seq_pkg::TRIG_CYCLES
) (
    input  wire logic                         core_clk,
    input  wire logic                         nrst,
    input  wire logic                         ce,
    input  wire logic                         clk_jack,
    input  wire logic                         ext_load_jack,
    input  wire logic                         rand_above,
    input  wire logic [seq_pkg::ADDR_W-1:0]   addr,
    input  wire logic [seq_pkg::DATA_W-1:0]   wr_data,
    input  wire logic                         wr_stb,
    input  wire logic                         rd_stb,
    output logic      [seq_pkg::DATA_W-1:0]   rd_data,
    output logic      [seq_pkg::STAGES-1:0]   stage_leds,
    output logic      [seq_pkg::BUSES-1:0]    bus_gate,
    output logic      [seq_pkg::BUSES-1:0]    bus_trig,
    output logic                              master_gate,
    output logic                              master_trig,
    output logic                              rand_led
);
    localparam int S = seq_pkg::STAGES;
    localparam int H = seq_pkg::HALF;
    localparam int B = seq_pkg::BUSES;

    // Returns the bus index a step is routed to; code three folds onto bus three.
    function automatic logic [1:0] bus_of(input logic [seq_pkg::DATA_W-1:0] route,
                                          input int step);
        logic [1:0] code;
        code = route[step*seq_pkg::ROUTE_W +: seq_pkg::ROUTE_W];
        bus_of = (code == 2'h3) ? 2'h2 : code;
    endfunction

    // Pin synchronisers: index 0 clock jack, 1 external load, 2 random comparator.
    logic [2:0]                 meta_q;
    logic [2:0]                 sync_q;
    logic [1:0]                 prev_q;

    logic [seq_pkg::DATA_W-1:0] ctrl_q;
    logic [S-1:0]               pattern_q;
    logic [seq_pkg::DATA_W-1:0] route_q;
    logic [S-1:0]               sr_q;
    logic                       fire_q;
    logic                       bus1_prev_q;
    logic [seq_pkg::DATA_W-1:0] rd_data_q;
    logic                       master_gate_q;
    logic                       master_trig_q;
    logic                       rand_led_q;
    logic [B-1:0]               bus_active;
    logic [B-1:0]               gate_w;
    logic [B-1:0]               trig_w;

    wire clk_en     = ctrl_q[seq_pkg::CTRL_CLK_EN_BIT];
    wire random_md  = ctrl_q[seq_pkg::CTRL_RANDOM_BIT];
    wire loop16     = ctrl_q[seq_pkg::CTRL_LOOP16_BIT];
    wire invert_b   = ctrl_q[seq_pkg::CTRL_INVERT_B_BIT];
    wire ext_ld_en  = ctrl_q[seq_pkg::CTRL_EXT_LOAD_EN_BIT];
    wire reload_en  = ctrl_q[seq_pkg::CTRL_BUS1_RELOAD_BIT];
    wire [B-1:0] merge = ctrl_q[seq_pkg::CTRL_MERGE_LSB +: B];

    wire clk_level  = sync_q[0] & clk_en;
    wire clk_rise   = sync_q[0] & ~prev_q[0] & clk_en;
    wire ext_rise   = sync_q[1] & ~prev_q[1];
    wire rand_s     = sync_q[2];

    // Register decode.
    wire hit_ctrl    = (addr == seq_pkg::CTRL_OFFS);
    wire hit_pattern = (addr == seq_pkg::PATTERN_OFFS);
    wire hit_route   = (addr == seq_pkg::ROUTE_OFFS);
    wire hit_cmd     = (addr == seq_pkg::CMD_OFFS);
    wire hit_status  = (addr == seq_pkg::STATUS_OFFS);

    wire man_load = wr_stb & hit_cmd & wr_data[seq_pkg::CMD_LOAD_BIT];
    wire man_step = wr_stb & hit_cmd & wr_data[seq_pkg::CMD_STEP_BIT];

    // Events that move the register.
    wire bus1_rise = gate_w[0] & ~bus1_prev_q;
    wire load_evt  = man_load
                   | (ext_rise & ext_ld_en)
                   | (bus1_rise & reload_en);
    wire step_evt  = clk_rise | man_step;

    // Loop feedback; section A is stages 0..H-1, section B is H..S-1.
    wire b_recirc = sr_q[S-1] ^ invert_b;
    wire a_in     = random_md ? rand_s : (loop16 ? b_recirc : sr_q[H-1]);
    wire b_in     = loop16 ? sr_q[H-1] : (random_md ? rand_s : b_recirc);
    wire [S-1:0] shift_d = {sr_q[S-2:H], b_in, sr_q[H-2:0], a_in};

    // Loading has priority over stepping when both land in one cycle.
    wire [S-1:0] sr_d = load_evt ? pattern_q : (step_evt ? shift_d : sr_q);

    wire [seq_pkg::DATA_W-1:0] status_w =
        {{(seq_pkg::DATA_W - seq_pkg::STAT_MASTER_BIT - 1){1'b0}},
         master_gate_q, rand_led_q, gate_w, sr_q};

    wire [seq_pkg::DATA_W-1:0] rd_mux =
          hit_ctrl    ? ctrl_q
        : hit_pattern ? {{(seq_pkg::DATA_W - S){1'b0}}, pattern_q}
        : hit_route   ? route_q
        : hit_status  ? status_w
        : 32'h0000_0000;

    // Each step drives one bus only, so the bus lines are a plain OR per bus.
    always_comb
    begin
        bus_active = '0;
        for (int i = 0; i < S; i++)
        begin
            if (sr_q[i])
            begin
                bus_active[bus_of(route_q, i)] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
            prev_q <= 2'h0;
        end
        else if (ce)
        begin
            meta_q <= {rand_above, ext_load_jack, clk_jack};
            sync_q <= meta_q;
            prev_q <= sync_q[1:0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q    <= seq_pkg::CTRL_RESET;
            pattern_q <= seq_pkg::PATTERN_RESET;
            route_q   <= seq_pkg::ROUTE_RESET;
        end
        else if (ce && wr_stb)
        begin
            if (hit_ctrl)
            begin
                ctrl_q <= wr_data & seq_pkg::CTRL_MASK;
            end
            if (hit_pattern)
            begin
                pattern_q <= wr_data[S-1:0];
            end
            if (hit_route)
            begin
                route_q <= wr_data;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sr_q        <= '0;
            fire_q      <= 1'b0;
            bus1_prev_q <= 1'b0;
        end
        else if (ce)
        begin
            sr_q        <= sr_d;
            fire_q      <= step_evt | load_evt;
            bus1_prev_q <= gate_w[0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_data_q     <= '0;
            master_gate_q <= 1'b0;
            master_trig_q <= 1'b0;
            rand_led_q    <= 1'b0;
        end
        else if (ce)
        begin
            rd_data_q     <= rd_stb ? rd_mux : '0;
            master_gate_q <= clk_level;
            master_trig_q <= clk_rise;
            rand_led_q    <= rand_s;
        end
    end

    // The trigger stage reads the register one cycle after it moved.
    for (genvar g = 0; g < B; g++)
    begin : g_bus
        gate_bus_shaper #(
            .TRIG_CYCLES (TRIG_CYCLES)
        ) u_shaper (
            .core_clk  (core_clk),
            .nrst      (nrst),
            .ce        (ce),
            .active    (bus_active[g]),
            .clk_level (clk_level),
            .fire      (fire_q),
            .merge     (merge[g]),
            .gate_q    (gate_w[g]),
            .trig_q    (trig_w[g])
        );
    end

    assign rd_data     = rd_data_q;
    assign stage_leds  = sr_q;
    assign bus_gate    = gate_w;
    assign bus_trig    = trig_w;
    assign master_gate = master_gate_q;
    assign master_trig = master_trig_q;
    assign rand_led    = rand_led_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_bus1_rise;
        (!gate_w[0] && ce) ##1 (gate_w[0] && reload_en && ce);
    endsequence

    a_load_copy: assert property (
        man_load && ce |=> sr_q == $past(pattern_q))
        else $error("Manual load did not copy the pattern.");

    a_ext_load: assert property (
        ext_rise && ext_ld_en && ce |=> sr_q == $past(pattern_q))
        else $error("Enabled external load edge did not load the pattern.");

    a_ext_gated: assert property (
        ext_rise && !ext_ld_en && !man_load && !(bus1_rise && reload_en)
        && !step_evt && ce |=> $stable(sr_q))
        else $error("Disabled external load changed the register.");

    a_bus1_reload: assert property (
        s_bus1_rise |=> sr_q == $past(pattern_q))
        else $error("Bus one rising edge did not reload the pattern.");

    a_shift_chain: assert property (
        step_evt && !load_evt && ce |=> sr_q[S-1:H+1] == $past(sr_q[S-2:H])
        && sr_q[H-1:1] == $past(sr_q[H-2:0]))
        else $error("Step did not move every stage by one position.");

    a_split_loops: assert property (
        step_evt && !load_evt && !loop16 && !random_md && ce
        |=> sr_q[0] == $past(sr_q[H-1]) && sr_q[H] == $past(b_recirc))
        else $error("Split mode loops did not recirculate within each half.");

    a_long_loop: assert property (
        step_evt && !load_evt && loop16 && !random_md && ce
        |=> sr_q[H] == $past(sr_q[H-1]) && sr_q[0] == $past(b_recirc))
        else $error("Sixteen stage loop did not chain the two halves.");

    a_invert_b: assert property (
        step_evt && !load_evt && !loop16 && !random_md && invert_b && ce
        |=> sr_q[H] != $past(sr_q[S-1]))
        else $error("Section B recirculated data was not inverted.");

    a_rand_insert: assert property (
        step_evt && !load_evt && random_md && ce |=> sr_q[0] == $past(rand_s))
        else $error("Random mode did not insert the comparator level.");

    a_clock_blocked: assert property (
        !clk_en && !man_step && !load_evt && ce |=> $stable(sr_q))
        else $error("Register moved while the clock input was disabled.");

    a_manual_step: assert property (
        man_step && !load_evt && ce |=> sr_q[1] == $past(sr_q[0]))
        else $error("Manual step did not advance the register.");

    a_one_bus: assert property (
        (sr_q == {{(S-1){1'b0}}, 1'b1}) |-> $onehot(bus_active))
        else $error("A single active step reached other than exactly one bus.");

    a_read_timing: assert property (
        rd_stb && hit_pattern && ce |=> rd_data == {{(seq_pkg::DATA_W - S){1'b0}},
        $past(pattern_q)})
        else $error("Read data did not appear in the cycle after the strobe.");

endmodule

// [verification/panel_model.sv]
// Behavioural model of the panel jacks that feed the sequencer core.
`timescale 1ns/1ps
module panel_model (
    input  wire logic core_clk,
    output logic      clk_jack,
    output logic      ext_load_jack,
    output logic      rand_above
);
    initial
    begin
        clk_jack      = 1'b0;
        ext_load_jack = 1'b0;
        rand_above    = 1'b0;
    end

    // The random level is settled well before any clock rise so it has crossed the synchroniser.
    task automatic set_rand(input logic v);
        @(posedge core_clk);
        rand_above <= v;
        repeat (4) @(posedge core_clk);
    endtask

    // The clock stays low between pulses; the high time varies to give prompt and slow edges.
    task automatic clock_pulse(input int hi);
        @(posedge core_clk);
        clk_jack <= 1'b1;
        repeat (hi) @(posedge core_clk);
        clk_jack <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask

    task automatic load_pulse();
        @(posedge core_clk);
        ext_load_jack <= 1'b1;
        repeat (3) @(posedge core_clk);
        ext_load_jack <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
endmodule

// [verification/tb_top.sv]
// Self-checking testbench for the step pattern shift sequencer core.
`timescale 1ns/1ps
module tb_top;
    typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
    logic        core_clk;
    logic        nrst;
    logic        ce;
    wire logic   clk_jack;
    wire logic   ext_load_jack;
    wire logic   rand_above;
    logic [7:0]  addr;
    logic [31:0] wr_data;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rd_data;
    logic        rd_seen;
    note_t       exp_q[$];
    note_t       nt;
    int          failures;
    int          n_tests;
    logic [15:0] p;
    logic [15:0] sr;
    logic [31:0] ctl;
    logic        r;
    logic [15:0] stage_leds;
    logic [2:0]  bus_gate;
    logic [2:0]  bus_trig;
    logic        master_gate;
    logic        master_trig;
    logic        rand_led;
    logic        trig_prev = 1'b0;
    int          n_trig = 0;
    int          n_mtrig = 0;
    int          n_mgate = 0;
    int          t0;
    int          t1;

    step_sequencer_core #(.TRIG_CYCLES(4)) DUT (
        .core_clk(core_clk), .nrst(nrst), .ce(ce), .clk_jack(clk_jack),
        .ext_load_jack(ext_load_jack), .rand_above(rand_above), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .stage_leds(stage_leds), .bus_gate(bus_gate), .bus_trig(bus_trig),
        .master_gate(master_gate), .master_trig(master_trig), .rand_led(rand_led)
    );

    panel_model pm (
        .core_clk(core_clk), .clk_jack(clk_jack), .ext_load_jack(ext_load_jack),
        .rand_above(rand_above)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic results();
        if (exp_q.size() != 0)
            failures++;
        if (failures == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] e, input logic [31:0] m, input logic [31:0] s);
        n_tests++;
        if ((s & m) !== (e & m))
        begin
            failures++;
            $display("[ERR] rd_data expected %h seen %h", e & m, s & m);
        end
    endtask

    task automatic cmp_out(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge core_clk);
        wr_stb  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge core_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        exp_q.push_back('{e, m});
        @(posedge core_clk);
        rd_stb <= 1'b0;
    endtask

    task automatic stat(input logic [15:0] e);
        repeat (3) @(posedge core_clk);
        rd(seq_pkg::STATUS_OFFS, {16'h0000, e}, 32'h0000_FFFF);
    endtask

    // Stage one takes the random bit or the end of its loop; split mode also refills stage nine.
    function automatic logic [15:0] nxt(input logic [15:0] c, input logic [31:0] k,
                                        input logic rb);
        logic [15:0] n;
        n = {c[14:0], 1'b0};
        if (k[2])
            n[0] = k[1] ? rb : (c[15] ^ k[3]);
        else
        begin
            n[0] = k[1] ? rb : c[7];
            n[8] = k[1] ? rb : (c[15] ^ k[3]);
        end
        return n;
    endfunction

    always @(posedge core_clk)
        rd_seen <= rd_stb;

    // Trigger pulses and master gate high cycles are counted on the falling edge, where the outputs have settled.
    always @(negedge core_clk)
    begin
        trig_prev <= bus_trig[0];
        if (bus_trig[0] && !trig_prev)
            n_trig++;
        if (master_trig)
            n_mtrig++;
        if (master_gate)
            n_mgate++;
    end

    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
    always @(negedge core_clk)
    begin
        if (rd_seen)
        begin
            if (exp_q.size() == 0)
                failures++;
            else
            begin
                nt = exp_q.pop_front();
                cmp(nt.e, nt.m, rd_data);
            end
        end
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        failures++;
        results();
    end

    initial
    begin
        nrst = 1'b0;
        ce = 1'b1;
        addr = 8'h00;
        wr_data = 32'h0000_0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        rd_seen = 1'b0;
        failures = 0;
        n_tests = 0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        void'($urandom(32'h3C6C));
        rd(seq_pkg::CTRL_OFFS, 32'h0000_0011, 32'hFFFF_FFFF);
        rd(seq_pkg::PATTERN_OFFS, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(seq_pkg::ROUTE_OFFS, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(seq_pkg::CMD_OFFS, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(8'h14, 32'h0000_0000, 32'hFFFF_FFFF);
        p = 16'($urandom);
        wr(seq_pkg::PATTERN_OFFS, {16'h0000, p});
        ce <= 1'b0;
        wr(seq_pkg::PATTERN_OFFS, {16'h0000, ~p});
        ce <= 1'b1;
        rd(seq_pkg::PATTERN_OFFS, {16'h0000, p}, 32'hFFFF_FFFF);
        wr(seq_pkg::CMD_OFFS, 32'h0000_0001);
        sr = p;
        stat(sr);
        for (int i = 0; i < 4; i++)
        begin
            ctl = 32'h0000_0011 | (32'(i) << 2);
            wr(seq_pkg::CTRL_OFFS, ctl);
            for (int j = 0; j < 3; j++)
            begin
                wr(seq_pkg::CMD_OFFS, 32'h0000_0002);
                sr = nxt(sr, ctl, 1'b0);
                stat(sr);
            end
        end
        wr(seq_pkg::CMD_OFFS, 32'h0000_0003);
        sr = p;
        stat(sr);
        t0 = n_mtrig;
        t1 = n_mgate;
        for (int i = 0; i < 6; i++)
        begin
            ctl = (i < 2) ? 32'h0000_0015 : 32'h0000_0013;
            r = 1'($urandom);
            wr(seq_pkg::CTRL_OFFS, ctl);
            pm.set_rand(r);
            pm.clock_pulse(1 + 3 * i);
            sr = nxt(sr, ctl, r);
            stat(sr);
        end
        wr(seq_pkg::CTRL_OFFS, 32'h0000_0012);
        pm.clock_pulse(2);
        stat(sr);
        cmp_out("master_trig", 32'h0000_0006, 32'(n_mtrig - t0));
        cmp_out("master_gate", 32'h0000_0033, 32'(n_mgate - t1));
        wr(seq_pkg::PATTERN_OFFS, {16'h0000, ~p});
        wr(seq_pkg::CTRL_OFFS, 32'h0000_0001);
        pm.load_pulse();
        stat(sr);
        wr(seq_pkg::CTRL_OFFS, 32'h0000_0011);
        pm.load_pulse();
        stat(~p);
        wr(seq_pkg::PATTERN_OFFS, 32'h0000_FFFF);
        wr(seq_pkg::CMD_OFFS, 32'h0000_0001);
        for (int b = 0; b < 4; b++)
        begin
            wr(seq_pkg::ROUTE_OFFS, {16{2'(b)}});
            wr(seq_pkg::CTRL_OFFS, 32'h0000_0711);
            wr(seq_pkg::CMD_OFFS, 32'h0000_0002);
            repeat (3) @(posedge core_clk);
            rd(seq_pkg::ROUTE_OFFS, {16{2'(b)}}, 32'hFFFF_FFFF);
            rd(seq_pkg::STATUS_OFFS, {13'h0, 3'(1 << ((b > 2) ? 2 : b)), 16'hFFFF},
               32'h0007_FFFF);
            wr(seq_pkg::CTRL_OFFS, 32'h0000_0011);
            repeat (3) @(posedge core_clk);
            rd(seq_pkg::STATUS_OFFS, 32'h0000_FFFF, 32'h0007_FFFF);
        end
        wr(seq_pkg::ROUTE_OFFS, 32'h0000_0000);
        wr(seq_pkg::PATTERN_OFFS, 32'h0000_0000);
        wr(seq_pkg::CMD_OFFS, 32'h0000_0001);
        wr(seq_pkg::PATTERN_OFFS, 32'h0000_FFFF);
        wr(seq_pkg::CTRL_OFFS, 32'h0000_0133);
        pm.set_rand(1'b1);
        pm.clock_pulse(2);
        repeat (8) @(posedge core_clk);
        stat(16'hFFFF);
        wr(seq_pkg::ROUTE_OFFS, 32'hFFFF_FFF0);
        wr(seq_pkg::PATTERN_OFFS, 32'h0000_0000);
        wr(seq_pkg::CMD_OFFS, 32'h0000_0001);
        wr(seq_pkg::PATTERN_OFFS, 32'h0000_0001);
        // Steps one and two feed bus one: merged they give one trigger, unmerged two.
        for (int m = 0; m < 2; m++)
        begin
            wr(seq_pkg::CTRL_OFFS, (m == 0) ? 32'h0000_0111 : 32'h0000_0011);
            t0 = n_trig;
            for (int j = 0; j < 3; j++)
            begin
                wr(seq_pkg::CMD_OFFS, (j == 0) ? 32'h0000_0001 : 32'h0000_0002);
                repeat (8) @(posedge core_clk);
                if (j == 0)
                    cmp_out("bus_gate", 32'((m == 0) ? 1 : 0), 32'(bus_gate));
            end
            cmp_out("bus_trig", 32'(1 + m), 32'(n_trig - t0));
        end
        cmp_out("stage_leds", 32'h0000_0004, 32'(stage_leds));
        cmp_out("rand_led", 32'h0000_0001, 32'(rand_led));
        repeat (4) @(posedge core_clk);
        results();
    end
endmodule
